// ---- dar_map.vh ----
`ifndef DAR_MAP_VH
`define DAR_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DAR_OFS_TEMP_HIGH 8'h60
`define DAR_OFS_TEMP_LOW 8'h61
`define DAR_OFS_VOLT_HIGH 8'h62
`define DAR_OFS_VOLT_LOW 8'h63
`define DAR_OFS_BIAS_HIGH 8'h64
`define DAR_OFS_BIAS_LOW 8'h65
`define DAR_OFS_TXP_HIGH 8'h66
`define DAR_OFS_TXP_LOW 8'h67
`define DAR_OFS_RXP_HIGH 8'h68
`define DAR_OFS_RXP_LOW 8'h69
`define DAR_OFS_CTRL 8'h6e

// ----------------------------------------------------------------
// link_control_status bit positions
// ----------------------------------------------------------------
`define DAR_BIT_TX_OFF_PIN 7
`define DAR_BIT_SOFT_TX_OFF 6
`define DAR_BIT_RATE_PIN1 5
`define DAR_BIT_RATE_PIN0 4
`define DAR_BIT_SOFT_RATE0 3
`define DAR_BIT_TX_FAULT 2
`define DAR_BIT_SIG_ABSENT 1
`define DAR_BIT_POR 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DAR_RST_RESULT 16'h0000
`define DAR_RST_BYTE 8'h00
`define DAR_RST_POR_BUSY 1'b1

// ----------------------------------------------------------------
// conversion channel codes
// ----------------------------------------------------------------
`define DAR_CH_TEMP 3'h0
`define DAR_CH_VOLT 3'h1
`define DAR_CH_BIAS 3'h2
`define DAR_CH_TXP 3'h3
`define DAR_CH_RXP 3'h4

// ----------------------------------------------------------------
// arithmetic unit: slope is unsigned 8.8, offset is signed
// ----------------------------------------------------------------
`define DAR_SLOPE_FRAC 8
`define DAR_ALL_SEEN 5'h1f

`endif

// ---- dar_cal.v ----
// ----------------------------------------------------------------
// slope and offset arithmetic, saturated to 16 bits unsigned
// ----------------------------------------------------------------
`include "dar_map.vh"

module dar_cal (
  input wire [15:0] raw,
  input wire [15:0] slope,
  input wire [15:0] offset,
  output reg [15:0] result
);

  reg [31:0] prod;
  reg [25:0] sum;

  always @*
  begin
    prod = {16'h0000, raw} * {16'h0000, slope};
    // offset is two's complement; a negative total clamps to zero
    // the full scaled word is kept so a negative offset cannot hide an overflow
    sum = {2'b00, prod[31:8]} + {{10{offset[15]}}, offset};
    if (sum[25])
      result = 16'h0000;
    else if (sum[24:16] != 9'h000)
      result = 16'hffff;
    else
      result = sum[15:0];
  end

endmodule

// ---- dar_pair.v ----
// ----------------------------------------------------------------
// one high/low result pair, stored as a single 16-bit word
// ----------------------------------------------------------------
`include "dar_map.vh"

module dar_pair #(
  parameter RAW_W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire ext_mode,
  input wire [11:0] raw,
  input wire [15:0] cal,
  output reg [15:0] pair_q,
  output reg valid_q
);

  reg [15:0] pair_d;

  always @*
  begin
    if (!ext_mode)
      pair_d = cal;
    else if (RAW_W == 12)
      pair_d = {raw, 4'h0};
    else
      pair_d = {raw[11:4], 8'h00};
  end

  // both bytes change on the same edge, never one at a time
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pair_q <= `DAR_RST_RESULT;
      valid_q <= 1'b0;
    end
    else if (load)
    begin
      pair_q <= pair_d;
      valid_q <= 1'b1;
    end
  end

endmodule

// ---- dar_top.v ----
`include "dar_map.vh"

module dar_top (
  clk,
  rst_n,
  cal_external,
  conv_valid,
  conv_chan,
  conv_data,
  conv_cycle_done,
  voltage_slope_coeff,
  voltage_offset_coeff,
  bias_slope_coeff,
  bias_offset_coeff,
  tx_power_slope_coeff,
  tx_power_offset_coeff,
  rx_power_slope_coeff_set,
  rx_power_offset_coeff_set,
  rx_coeff_index,
  tx_off_pin,
  rate_pin1,
  rate_pin0,
  tx_fault_pin,
  signal_absent_pin,
  reg_addr,
  reg_rd,
  reg_wr,
  reg_wdata,
  reg_rdata_q,
  reg_rvalid_q,
  laser_off_q,
  rate_pin0_drive_q,
  por_busy_q
);

  input wire clk;
  input wire rst_n;
  input wire cal_external;
  input wire conv_valid;
  input wire [2:0] conv_chan;
  input wire [11:0] conv_data;
  input wire conv_cycle_done;
  input wire [15:0] voltage_slope_coeff;
  input wire [15:0] voltage_offset_coeff;
  input wire [15:0] bias_slope_coeff;
  input wire [15:0] bias_offset_coeff;
  input wire [15:0] tx_power_slope_coeff;
  input wire [15:0] tx_power_offset_coeff;
  input wire [127:0] rx_power_slope_coeff_set;
  input wire [127:0] rx_power_offset_coeff_set;
  input wire [2:0] rx_coeff_index;
  input wire tx_off_pin;
  input wire rate_pin1;
  input wire rate_pin0;
  input wire tx_fault_pin;
  input wire signal_absent_pin;
  input wire [7:0] reg_addr;
  input wire reg_rd;
  input wire reg_wr;
  input wire [7:0] reg_wdata;
  output reg [7:0] reg_rdata_q;
  output reg reg_rvalid_q;
  output reg laser_off_q;
  output reg rate_pin0_drive_q;
  output reg por_busy_q;

  // ----------------------------------------------------------------
  // power-up sequencing states
  // ----------------------------------------------------------------
  localparam [2:0] ST_POR = 3'b001;
  localparam [2:0] ST_LAST = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [4:0] seen_q;
  reg [7:0] temp_high_q;
  reg temp_valid_q;
  reg soft_tx_off_q;
  reg soft_rate0_q;

  wire [15:0] raw16;
  wire [15:0] volt_cal;
  wire [15:0] bias_cal;
  wire [15:0] txp_cal;
  wire [15:0] rxp_cal;
  wire [15:0] rx_slope_sel;
  wire [15:0] rx_offset_sel;
  wire [15:0] volt_pair;
  wire [15:0] bias_pair;
  wire [15:0] txp_pair;
  wire [15:0] rxp_pair;
  wire volt_valid;
  wire bias_valid;
  wire txp_valid;
  wire rxp_valid;
  wire load_volt;
  wire load_bias;
  wire load_txp;
  wire load_rxp;
  wire [4:0] seen_now;
  wire [7:0] ctrl_byte;

  // ----------------------------------------------------------------
  // conversion steering
  // ----------------------------------------------------------------
  // the raw word is left aligned so the unit sees full-scale values
  assign raw16 = {conv_data, 4'h0};
  assign load_volt = conv_valid && (conv_chan == `DAR_CH_VOLT);
  assign load_bias = conv_valid && (conv_chan == `DAR_CH_BIAS);
  assign load_txp = conv_valid && (conv_chan == `DAR_CH_TXP);
  assign load_rxp = conv_valid && (conv_chan == `DAR_CH_RXP);

  // index picks one of eight packed 16-bit coefficient words
  assign rx_slope_sel = rx_power_slope_coeff_set[{rx_coeff_index, 4'h0} +: 16];
  assign rx_offset_sel = rx_power_offset_coeff_set[{rx_coeff_index, 4'h0} +: 16];

  // ----------------------------------------------------------------
  // arithmetic units
  // ----------------------------------------------------------------
  dar_cal u_cal_volt (
    .raw(raw16),
    .slope(voltage_slope_coeff),
    .offset(voltage_offset_coeff),
    .result(volt_cal)
  );

  dar_cal u_cal_bias (
    .raw(raw16),
    .slope(bias_slope_coeff),
    .offset(bias_offset_coeff),
    .result(bias_cal)
  );

  dar_cal u_cal_txp (
    .raw(raw16),
    .slope(tx_power_slope_coeff),
    .offset(tx_power_offset_coeff),
    .result(txp_cal)
  );

  dar_cal u_cal_rxp (
    .raw(raw16),
    .slope(rx_slope_sel),
    .offset(rx_offset_sel),
    .result(rxp_cal)
  );

  // ----------------------------------------------------------------
  // result pairs
  // ----------------------------------------------------------------
  dar_pair #(
    .RAW_W(8)
  ) u_pair_volt (
    .clk(clk),
    .rst_n(rst_n),
    .load(load_volt),
    .ext_mode(cal_external),
    .raw(conv_data),
    .cal(volt_cal),
    .pair_q(volt_pair),
    .valid_q(volt_valid)
  );

  dar_pair #(
    .RAW_W(8)
  ) u_pair_bias (
    .clk(clk),
    .rst_n(rst_n),
    .load(load_bias),
    .ext_mode(cal_external),
    .raw(conv_data),
    .cal(bias_cal),
    .pair_q(bias_pair),
    .valid_q(bias_valid)
  );

  dar_pair #(
    .RAW_W(8)
  ) u_pair_txp (
    .clk(clk),
    .rst_n(rst_n),
    .load(load_txp),
    .ext_mode(cal_external),
    .raw(conv_data),
    .cal(txp_cal),
    .pair_q(txp_pair),
    .valid_q(txp_valid)
  );

  dar_pair #(
    .RAW_W(12)
  ) u_pair_rxp (
    .clk(clk),
    .rst_n(rst_n),
    .load(load_rxp),
    .ext_mode(cal_external),
    .raw(conv_data),
    .cal(rxp_cal),
    .pair_q(rxp_pair),
    .valid_q(rxp_valid)
  );

  // ----------------------------------------------------------------
  // temperature high byte
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temp_high_q <= `DAR_RST_BYTE;
      temp_valid_q <= 1'b0;
    end
    else if (conv_valid && (conv_chan == `DAR_CH_TEMP))
    begin
      temp_high_q <= conv_data[11:4];
      temp_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // power-up tracking
  // ----------------------------------------------------------------
  assign seen_now = {rxp_valid, txp_valid, bias_valid, volt_valid, temp_valid_q};

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_POR:
      begin
        // every channel has landed; wait for the sweep to close
        if (seen_q == `DAR_ALL_SEEN)
          state_d = ST_LAST;
      end
      ST_LAST:
      begin
        if (conv_cycle_done)
          state_d = ST_RUN;
      end
      ST_RUN:
        state_d = ST_RUN;
      default:
        state_d = ST_POR;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_POR;
      seen_q <= 5'h00;
      por_busy_q <= `DAR_RST_POR_BUSY;
    end
    else
    begin
      state_q <= state_d;
      seen_q <= seen_now;
      por_busy_q <= (state_d != ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------
  assign ctrl_byte = {tx_off_pin, soft_tx_off_q, rate_pin1, rate_pin0,
                      soft_rate0_q, tx_fault_pin, signal_absent_pin, por_busy_q};

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      soft_tx_off_q <= 1'b0;
      soft_rate0_q <= 1'b0;
    end
    else if (reg_wr && (reg_addr == `DAR_OFS_CTRL))
    begin
      // only the two soft bits take writes; the rest mirror pins and the power-up flag
      soft_tx_off_q <= reg_wdata[`DAR_BIT_SOFT_TX_OFF];
      soft_rate0_q <= reg_wdata[`DAR_BIT_SOFT_RATE0];
    end
  end

  // pin levels are registered so the outputs stay glitch free
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      laser_off_q <= 1'b0;
      rate_pin0_drive_q <= 1'b0;
    end
    else
    begin
      laser_off_q <= tx_off_pin | soft_tx_off_q;
      rate_pin0_drive_q <= soft_rate0_q;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // a high-byte read freezes the low byte of the same word, so the
  // following low-byte read cannot pick up a newer conversion
  reg [7:0] volt_low_q;
  reg [7:0] bias_low_q;
  reg [7:0] txp_low_q;
  reg [7:0] rxp_low_q;
  reg [7:0] rdata_d;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      volt_low_q <= `DAR_RST_BYTE;
      bias_low_q <= `DAR_RST_BYTE;
      txp_low_q <= `DAR_RST_BYTE;
      rxp_low_q <= `DAR_RST_BYTE;
    end
    else if (reg_rd)
    begin
      if (reg_addr == `DAR_OFS_VOLT_HIGH)
        volt_low_q <= volt_pair[7:0];
      if (reg_addr == `DAR_OFS_BIAS_HIGH)
        bias_low_q <= bias_pair[7:0];
      if (reg_addr == `DAR_OFS_TXP_HIGH)
        txp_low_q <= txp_pair[7:0];
      if (reg_addr == `DAR_OFS_RXP_HIGH)
        rxp_low_q <= rxp_pair[7:0];
    end
  end

  always @*
  begin
    case (reg_addr)
      `DAR_OFS_TEMP_HIGH: rdata_d = temp_high_q;
      `DAR_OFS_TEMP_LOW: rdata_d = `DAR_RST_BYTE;
      `DAR_OFS_VOLT_HIGH: rdata_d = volt_pair[15:8];
      `DAR_OFS_VOLT_LOW: rdata_d = volt_low_q;
      `DAR_OFS_BIAS_HIGH: rdata_d = bias_pair[15:8];
      `DAR_OFS_BIAS_LOW: rdata_d = bias_low_q;
      `DAR_OFS_TXP_HIGH: rdata_d = txp_pair[15:8];
      `DAR_OFS_TXP_LOW: rdata_d = txp_low_q;
      `DAR_OFS_RXP_HIGH: rdata_d = rxp_pair[15:8];
      `DAR_OFS_RXP_LOW: rdata_d = rxp_low_q;
      `DAR_OFS_CTRL: rdata_d = ctrl_byte;
      default: rdata_d = `DAR_RST_BYTE;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= `DAR_RST_BYTE;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd)
        reg_rdata_q <= rdata_d;
    end
  end

endmodule

// ---- dar_chk.sv ----
// ----------------------------------------
// readout port checker
// ----------------------------------------
module dar_chk (
  input wire clk,
  input wire rst_n,
  input wire cal_external,
  input wire conv_valid,
  input wire [2:0] conv_chan,
  input wire [11:0] conv_data,
  input wire conv_cycle_done,
  input wire tx_off_pin,
  input wire rate_pin1,
  input wire rate_pin0,
  input wire tx_fault_pin,
  input wire signal_absent_pin,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire reg_rvalid_q,
  input wire laser_off_q,
  input wire rate_pin0_drive_q,
  input wire por_busy_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire [4:0] pins = {tx_off_pin, rate_pin1, rate_pin0, tx_fault_pin, signal_absent_pin};
  wire ctl_rd = reg_rd && reg_addr == 8'h6e;
  wire ctl_wr = reg_wr && reg_addr == 8'h6e;
  wire mapped = (reg_addr[7:4] == 4'h6 && reg_addr[3:0] < 4'ha) || reg_addr == 8'h6e;
  wire [7:0] raw_hi = conv_data[11:4];
  wire wd_rate = reg_wdata[3];
  rd_answer_a: assert property (reg_rvalid_q == $past(reg_rd))
    else $error("read answer timing");
  unmapped_a: assert property (reg_rd && !mapped |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  // pins checked only when steady, though the status bits take the pin levels directly with no register between
  ctl_pins_a: assert property (ctl_rd && $stable(pins) |=>
    {reg_rdata_q[7], reg_rdata_q[5:4], reg_rdata_q[2:1]} == $past(pins))
    else $error("status pin bits wrong");
  ctl_por_a: assert property (ctl_rd |=> reg_rdata_q[0] == $past(por_busy_q))
    else $error("status power-up bit wrong");
  por_fall_a: assert property ($fell(por_busy_q) |->
    $past(conv_cycle_done) || $past(conv_cycle_done, 2))
    else $error("power-up ended without sweep end");
  soft_rate_a: assert property (ctl_wr |-> ##2 rate_pin0_drive_q == $past(wd_rate, 2))
    else $error("rate drive not following write");
  soft_off_a: assert property (ctl_wr && reg_wdata[6] |-> ##2 laser_off_q)
    else $error("soft off ignored");
  pin_off_a: assert property (tx_off_pin |=> laser_off_q)
    else $error("pin off ignored");
  bias_raw_a: assert property (conv_valid && cal_external && conv_chan == 3'h2 ##2
    reg_rd && reg_addr == 8'h64 |=> reg_rdata_q == $past(raw_hi, 3))
    else $error("raw bias high wrong");
  rx_raw_a: assert property (conv_valid && cal_external && conv_chan == 3'h4 ##2
    reg_rd && reg_addr == 8'h68 |=> reg_rdata_q == $past(raw_hi, 3))
    else $error("raw rx high wrong");
  cover property ($fell(por_busy_q));
  cover property (ctl_wr && reg_wdata[6]);
  cover property (reg_rd && !mapped);
endmodule
bind dar_top dar_chk u_chk (
  .clk, .rst_n, .cal_external, .conv_valid, .conv_chan, .conv_data, .conv_cycle_done,
  .tx_off_pin, .rate_pin1, .rate_pin0, .tx_fault_pin, .signal_absent_pin, .reg_addr,
  .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .laser_off_q,
  .rate_pin0_drive_q, .por_busy_q
);

// ---- dar_host.sv ----
// ----------------------------------------
// host side of the byte port
// ----------------------------------------
module dar_host (
  input wire clk,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // rd only drives address and strobe; no byte comes back here, checking the answer is the caller's job
  task rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    // released address is scrambled so nothing leans on a stale value
    reg_addr = ~a;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ---- diag_adc_result_registers_tb.sv ----
// ----------------------------------------
// readout bench
// ----------------------------------------
module diag_adc_result_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cal_external, conv_valid, conv_cycle_done;
  logic [2:0] conv_chan, rx_coeff_index;
  logic [11:0] conv_data, d;
  logic [4:0] pins;
  logic [15:0] slp [1:3];
  logic [15:0] ofs [1:3];
  logic [15:0] last [0:4];
  logic [127:0] rxs, rxo;
  logic [7:0] q [$];
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
  wire reg_rd, reg_wr, reg_rvalid_q, laser_off_q, rate_pin0_drive_q, por_busy_q;
  int n_mismatch, samples_checked;

  dar_host u_host (.clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);
  dar_top u_dut (
    .clk, .rst_n, .cal_external, .conv_valid, .conv_chan, .conv_data, .conv_cycle_done,
    .voltage_slope_coeff(slp[1]), .voltage_offset_coeff(ofs[1]),
    .bias_slope_coeff(slp[2]), .bias_offset_coeff(ofs[2]),
    .tx_power_slope_coeff(slp[3]), .tx_power_offset_coeff(ofs[3]),
    .rx_power_slope_coeff_set(rxs), .rx_power_offset_coeff_set(rxo), .rx_coeff_index,
    .tx_off_pin(pins[4]), .rate_pin1(pins[3]), .rate_pin0(pins[2]), .tx_fault_pin(pins[1]),
    .signal_absent_pin(pins[0]), .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_q,
    .reg_rvalid_q, .laser_off_q, .rate_pin0_drive_q, .por_busy_q
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [15:0] cal(input logic [11:0] x, input logic [15:0] s,
                                      input logic [15:0] o);
    longint r;
    r = ((longint'({x, 4'h0}) * s) >> 8) + longint'($signed(o));
    return r < 0 ? 16'h0000 : (r > 65535 ? 16'hffff : r[15:0]);
  endfunction

  task cmp(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    u_host.rd(a);
  endtask

  task pair(input logic [2:0] c, input logic [15:0] e);
    last[c] = e;
    rd({4'h6, c, 1'b0}, e[15:8]);
    rd({4'h6, c, 1'b1}, e[7:0]);
  endtask

  task cv(input logic [2:0] c, input logic [11:0] x);
    @(negedge clk);
    conv_chan = c;
    conv_data = x;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
  endtask

  task end_of_test();
    @(negedge clk);
    if (q.size() != 0)
    begin
      n_mismatch++;
      $display("MISMATCH %0t reads unanswered", $time);
    end
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // answers are sampled on the falling edge, clear of the launching edge
  always @(negedge clk)
  begin
    if (reg_rvalid_q === 1'b1)
      cmp(reg_rdata_q, q.size() != 0 ? q.pop_front() : 8'hxx);
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH %0t run hung", $time);
    end_of_test();
  end

  initial
  begin
    void'($urandom(19));
    rst_n = 1'b0;
    cal_external = 1'b1;
    conv_valid = 1'b0;
    conv_chan = 3'h0;
    conv_data = 12'h000;
    conv_cycle_done = 1'b0;
    rx_coeff_index = 3'h0;
    pins = 5'h00;
    // slopes kept under 2.0 so both clamp ends and the unclamped middle all show up
    for (int i = 1; i < 4; i++)
    begin
      slp[i] = 16'($urandom_range(0, 16'h01ff));
      ofs[i] = 16'($urandom_range(0, 8191) - 4096);
    end
    for (int k = 0; k < 8; k++)
    begin
      rxs[16*k +: 16] = 16'($urandom_range(0, 16'h01ff));
      rxo[16*k +: 16] = 16'($urandom_range(0, 8191) - 4096);
    end
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int a = 8'h60; a < 8'h70; a++)
      rd(8'(a), a == 8'h6e ? 8'h01 : 8'h00);
    for (int c = 0; c < 5; c++)
    begin
      d = 12'($urandom);
      cv(3'(c), d);
      pair(3'(c), c == 4 ? {d, 4'h0} : {d[11:4], 8'h00});
    end
    cmp({7'h0, por_busy_q}, 8'h01);
    @(negedge clk);
    conv_cycle_done = 1'b1;
    @(negedge clk);
    conv_cycle_done = 1'b0;
    repeat (2) @(negedge clk);
    cmp({7'h0, por_busy_q}, 8'h00);
    rd(8'h6e, 8'h00);
    cal_external = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      rx_coeff_index = 3'(k);
      for (int c = 1; c < 5; c++)
      begin
        d = 12'($urandom);
        cv(3'(c), d);
        pair(3'(c), c == 4 ? cal(d, rxs[16*k +: 16], rxo[16*k +: 16])
                           : cal(d, slp[c], ofs[c]));
      end
    end
    cal_external = 1'b1;
    cv(3'h4, 12'h5a5);
    rd(8'h68, 8'h5a);
    cv(3'h4, 12'h3c3);
    rd(8'h69, 8'h50);
    // channel code 7, above rx power, must leave the rx power pair alone
    cv(3'h7, 12'hfff);
    pair(3'h4, 16'h3c30);
    u_host.wr(8'h62, 8'hff);
    pair(3'h1, last[1]);
    pins = 5'($urandom);
    u_host.wr(8'h6e, 8'hff);
    repeat (2) @(negedge clk);
    cmp({6'h0, laser_off_q, rate_pin0_drive_q}, 8'h03);
    rd(8'h6e, {pins[4], 1'b1, pins[3:2], 1'b1, pins[1:0], 1'b0});
    u_host.wr(8'h6e, 8'h00);
    for (int t = 0; t < 2; t++)
    begin
      pins[4] = 1'(t);
      repeat (2) @(negedge clk);
      cmp({6'h0, laser_off_q, rate_pin0_drive_q}, {6'h0, 1'(t), 1'b0});
    end
    pins = 5'h00;
    u_host.wr(8'h6e, 8'h48);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    cmp({5'h0, laser_off_q, rate_pin0_drive_q, por_busy_q}, 8'h01);
    rst_n = 1'b1;
    rd(8'h69, 8'h00);
    rd(8'h6e, 8'h01);
    end_of_test();
  end
endmodule
